// ### swl_consts.svh
`ifndef SWL_CONSTS_SVH
`define SWL_CONSTS_SVH

// ==========================================================
// Register indexes, byte address is four times the index
`define SWL_IDX_PRIMARY 6'h0b
`define SWL_IDX_SECONDARY 6'h0d
`define SWL_IDX_WDOG_MODE 6'h0f
`define SWL_IDX_STATUS 6'h10

// ==========================================================
// Field positions
`define SWL_SRC_LSB 2
`define SWL_SRC_MSB 4
`define SWL_PRI_LEVEL_BIT 5
`define SWL_PRI_FLAG_BIT 7
`define SWL_SEC_LEVEL_BIT 6
`define SWL_WDOG_STOP_BIT 3

// ==========================================================
// Reset values
`define SWL_SRC_RESET 3'h0
`define SWL_LEVEL_RESET 1'h0
`define SWL_WDOG_STOP_RESET 1'h1

// ==========================================================
// Source codes and pin masks over {port3, port2, port0}
`define SWL_SRC_POR_ONLY 3'h0
`define SWL_SRC_NOR_P3 3'h3
`define SWL_SRC_NOR_P3_P0 3'h5
`define SWL_MASK_1 24'h000f00
`define SWL_MASK_2 24'h00ff00
`define SWL_MASK_3 24'h0e0000
`define SWL_MASK_4 24'h0e0000
`define SWL_MASK_5 24'h0e0081
`define SWL_MASK_6 24'h0e0081
`define SWL_MASK_7 24'h0e0700

// ==========================================================
// Power-on sequence timing
`define SWL_POR_TIME_NS 10000
`define SWL_CLK_PERIOD_NS 10
`define SWL_POR_CYCLES (`SWL_POR_TIME_NS / `SWL_CLK_PERIOD_NS)

`endif

// ### swl_pkg.sv
package swl_pkg;

  // ==========================================================
  // Port pin groups
  typedef struct packed {
    logic [7:0] p3;
    logic [7:0] p2;
    logic [7:0] p0;
  } swl_pins_t;

  // ==========================================================
  // Sequencer states
  typedef enum logic [3:0] {
    SWL_RUN = 4'h1,
    SWL_STOP = 4'h2,
    SWL_BROWN = 4'h4,
    SWL_POR = 4'h8
  } swl_state_t;

endpackage

// ### swl_stop_wake.sv
`timescale 1ns/1ps
`include "swl_consts.svh"

module swl_stop_wake #(
  parameter int POR_CYCLES = `SWL_POR_CYCLES
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // Avalon-MM slave
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Port pins and their direction
  input wire swl_pkg::swl_pins_t i_pins,
  input wire swl_pkg::swl_pins_t i_pin_is_output,
  // Power and core control
  input wire logic i_vdd_low,
  input wire logic i_stop_req,
  output logic o_in_stop,
  output logic o_wdt_run,
  output logic o_global_reset
);

  // ==========================================================
  // Input synchronisers
  swl_pkg::swl_pins_t pins_meta;
  swl_pkg::swl_pins_t pins_s;
  logic vdd_meta;
  logic vdd_low_s;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      pins_meta <= '0;
      pins_s <= '0;
      vdd_meta <= 1'b0;
      vdd_low_s <= 1'b0;
    end else begin
      pins_meta <= i_pins;
      pins_s <= pins_meta;
      vdd_meta <= i_vdd_low;
      vdd_low_s <= vdd_meta;
    end
  end

  // ==========================================================
  // Sequencer
  swl_pkg::swl_state_t state;
  logic [15:0] por_cnt;
  logic wake_p;
  logic wake_s;
  logic reg_rst;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      state <= swl_pkg::SWL_POR;
      por_cnt <= 16'(POR_CYCLES - 1);
    end else if (vdd_low_s) begin
      state <= swl_pkg::SWL_BROWN;
    end else begin
      case (state)
        swl_pkg::SWL_BROWN: begin
          state <= swl_pkg::SWL_POR;
          por_cnt <= 16'(POR_CYCLES - 1);
        end
        swl_pkg::SWL_POR: begin
          if (por_cnt == 16'h0000) begin
            state <= swl_pkg::SWL_RUN;
          end else begin
            por_cnt <= por_cnt - 16'h0001;
          end
        end
        swl_pkg::SWL_RUN: begin
          if (i_stop_req) begin
            state <= swl_pkg::SWL_STOP;
          end
        end
        swl_pkg::SWL_STOP: begin
          if (wake_p || wake_s) begin
            state <= swl_pkg::SWL_RUN;
          end
        end
        default: begin
          state <= swl_pkg::SWL_POR;
        end
      endcase
    end
  end

  assign reg_rst = i_reset || (state == swl_pkg::SWL_BROWN) || (state == swl_pkg::SWL_POR);
  assign o_global_reset = (state == swl_pkg::SWL_BROWN) || (state == swl_pkg::SWL_POR);
  assign o_in_stop = (state == swl_pkg::SWL_STOP);

  // ==========================================================
  // Avalon-MM slave, one wait state per access
  logic ack;
  logic req;
  logic acc;
  logic [2:0] src_p;
  logic [2:0] src_s;
  logic level_p;
  logic level_s;
  logic wdog_stop;
  logic wake_flag;

  assign req = i_avs_read || i_avs_write;
  assign acc = req && ack;
  assign o_avs_waitrequest = req && !ack;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      ack <= 1'b0;
    end else begin
      ack <= req && !ack;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_avs_readdata <= 32'h00000000;
    end else if (req && !ack && i_avs_read) begin
      o_avs_readdata <= 32'h00000000;
      if (i_avs_address == {`SWL_IDX_PRIMARY, 2'b00}) begin
        o_avs_readdata[`SWL_PRI_FLAG_BIT] <= wake_flag;
      end else if (i_avs_address == {`SWL_IDX_WDOG_MODE, 2'b00}) begin
        o_avs_readdata[`SWL_WDOG_STOP_BIT] <= wdog_stop;
      end else if (i_avs_address == {`SWL_IDX_STATUS, 2'b00}) begin
        o_avs_readdata[3:0] <= {wake_s, wake_p, o_wdt_run, o_in_stop};
      end
    end
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge i_ref_clk) begin
    if (reg_rst) begin
      src_p <= `SWL_SRC_RESET;
      level_p <= `SWL_LEVEL_RESET;
      src_s <= `SWL_SRC_RESET;
      level_s <= `SWL_LEVEL_RESET;
      wdog_stop <= `SWL_WDOG_STOP_RESET;
    end else if (acc && i_avs_write) begin
      if (i_avs_address == {`SWL_IDX_PRIMARY, 2'b00}) begin
        src_p <= i_avs_writedata[`SWL_SRC_MSB:`SWL_SRC_LSB];
        level_p <= i_avs_writedata[`SWL_PRI_LEVEL_BIT];
      end else if (i_avs_address == {`SWL_IDX_SECONDARY, 2'b00}) begin
        src_s <= i_avs_writedata[`SWL_SRC_MSB:`SWL_SRC_LSB];
        level_s <= i_avs_writedata[`SWL_SEC_LEVEL_BIT];
      end else if (i_avs_address == {`SWL_IDX_WDOG_MODE, 2'b00}) begin
        wdog_stop <= i_avs_writedata[`SWL_WDOG_STOP_BIT];
      end
    end
  end

  // Wake flag: set on recovery, cleared on stop entry, set wins
  always_ff @(posedge i_ref_clk) begin
    if (reg_rst) begin
      wake_flag <= 1'b0;
    end else if (o_in_stop && (wake_p || wake_s)) begin
      wake_flag <= 1'b1;
    end else if (state == swl_pkg::SWL_RUN && i_stop_req) begin
      wake_flag <= 1'b0;
    end
  end

  // ==========================================================
  // Watchdog run control
  assign o_wdt_run = !o_in_stop || wdog_stop;

  // ==========================================================
  // Wake combining logic
  function automatic logic [23:0] swl_mask(input logic [2:0] src);
    case (src)
      3'h1: swl_mask = `SWL_MASK_1;
      3'h2: swl_mask = `SWL_MASK_2;
      3'h3: swl_mask = `SWL_MASK_3;
      3'h4: swl_mask = `SWL_MASK_4;
      3'h5: swl_mask = `SWL_MASK_5;
      3'h6: swl_mask = `SWL_MASK_6;
      3'h7: swl_mask = `SWL_MASK_7;
      default: swl_mask = 24'h000000;
    endcase
  endfunction

  function automatic logic swl_wake(input logic [2:0] src, input logic level,
                                    input logic [23:0] pins, input logic [23:0] dir_out);
    logic [23:0] incl;
    logic comb;
    incl = swl_mask(src) & ~dir_out;
    if (src == `SWL_SRC_NOR_P3 || src == `SWL_SRC_NOR_P3_P0) begin
      comb = ~|(pins & incl);
    end else begin
      comb = ~&(pins | ~incl);
    end
    swl_wake = (src != `SWL_SRC_POR_ONLY) && (|incl) && (comb == level);
  endfunction

  assign wake_p = swl_wake(src_p, level_p, pins_s, i_pin_is_output);
  assign wake_s = swl_wake(src_s, level_s, pins_s, i_pin_is_output);

  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  AST_WAKE_EITHER: assert property (
    (o_in_stop && !vdd_low_s && (wake_p || wake_s)) |=> (state == swl_pkg::SWL_RUN) && wake_flag)
    else $error("Stop not left on wake event");

  AST_OUTPUT_IGNORED: assert property (
    (src_p == 3'h1 && (&i_pin_is_output.p2[3:0])) |-> !wake_p)
    else $error("Output pins counted as wake source");

  AST_WDOG_HALT: assert property (
    (o_in_stop && !wdog_stop) |-> !o_wdt_run)
    else $error("Watchdog running in stop while disabled");

  AST_WDOG_DEFAULT: assert property (
    (state == swl_pkg::SWL_POR) |=> wdog_stop)
    else $error("Watchdog stop bit not defaulted to one");

  AST_SEC_WRITE_ONLY: assert property (
    (acc && i_avs_read && i_avs_address == {`SWL_IDX_SECONDARY, 2'b00}) |-> o_avs_readdata == 32'h0)
    else $error("Secondary register readback not zero");

  AST_PRI_FLAG_RO: assert property (
    (acc && i_avs_write && !o_in_stop && !reg_rst && !i_stop_req) |=> $stable(wake_flag))
    else $error("Read-only recovery flag changed by write");

  AST_BROWN_HOLD: assert property (
    vdd_low_s |=> o_global_reset ##0 (state == swl_pkg::SWL_BROWN))
    else $error("Global reset not held under brown-out");

  AST_POR_AFTER_BROWN: assert property (
    (state == swl_pkg::SWL_BROWN && !vdd_low_s) |=> (state == swl_pkg::SWL_POR) && o_global_reset)
    else $error("No power-on sequence after brown-out");

  AST_SRC_NONE: assert property (
    (src_s == `SWL_SRC_POR_ONLY && src_p == `SWL_SRC_POR_ONLY && o_in_stop && !vdd_low_s)
      |=> o_in_stop)
    else $error("Wake with no recovery source selected");

  AST_LEVEL_LOW: assert property (
    (src_p == 3'h1 && !level_p
      && ((pins_s.p2[3:0] | i_pin_is_output.p2[3:0]) != 4'hf)) |-> !wake_p)
    else $error("Low-level wake fired with NAND output high");

endmodule

// ### swl_pin_model.sv
`timescale 1ns/1ps

// ==========================================================
// External port pins: take requested levels after a lag
module swl_pin_model (
  // Clock
  input wire logic i_ref_clk,
  // Requested levels and lag in cycles
  input wire swl_pkg::swl_pins_t i_target,
  input wire logic [3:0] i_lag,
  // Pin levels
  output swl_pkg::swl_pins_t o_pins
);
  swl_pkg::swl_pins_t pend = '0;
  logic [3:0] cnt = 4'h0;

  always @(posedge i_ref_clk) begin
    if (pend !== i_target) begin
      pend <= i_target;
      cnt <= i_lag;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else begin
      o_pins <= pend;
    end
  end
endmodule

// ### swl_stop_wake_test.sv
`timescale 1ns/1ps
`include "swl_consts.svh"

`define SWL_CHK(a, b, m) begin checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("CHECK FAILED %0t %s", $time, m); end end

module swl_stop_wake_test;
  localparam int POR = 4;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  swl_pkg::swl_pins_t pins, target = '0, dir = '0;
  logic [3:0] lag = 4'h0;
  logic vdd_low = 1'b0;
  logic stop_req = 1'b0;
  logic in_stop, wdt_run, global_reset;
  logic [31:0] exp_q[$];
  logic [23:0] masks[1:7];
  int error_cnt = 0;
  int checked = 0;

  swl_stop_wake #(.POR_CYCLES(POR)) uut (.i_ref_clk(ref_clk), .i_reset(reset),
    .i_avs_address(avs_address), .i_avs_read(avs_read), .i_avs_write(avs_write),
    .i_avs_writedata(avs_writedata), .o_avs_readdata(avs_readdata),
    .o_avs_waitrequest(avs_waitrequest), .i_pins(pins), .i_pin_is_output(dir),
    .i_vdd_low(vdd_low), .i_stop_req(stop_req), .o_in_stop(in_stop),
    .o_wdt_run(wdt_run), .o_global_reset(global_reset));

  swl_pin_model pin_model (.i_ref_clk(ref_clk), .i_target(target), .i_lag(lag),
    .o_pins(pins));

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  // ==========================================================
  // Read results against the oldest note
  always @(negedge ref_clk) begin
    if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
      `SWL_CHK(avs_readdata, exp_q.pop_front(), "read data")
    end
  end

  task automatic tally_and_finish();
    if (error_cnt == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Avalon-MM access, held until waitrequest is low
  task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] wd,
                     input logic [31:0] exp);
    @(posedge ref_clk);
    avs_address <= {idx, 2'b00};
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= {24'($urandom()), wd};
    if (!wr) exp_q.push_back(exp);
    do @(negedge ref_clk); while (avs_waitrequest !== 1'b0);
    @(posedge ref_clk);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // ==========================================================
  // Stop entry then wake by pins
  task automatic wake(input logic [7:0] pri, input logic [7:0] sec, input logic wd,
                      input logic [23:0] idle, input logic [23:0] act, input logic [23:0] d);
    bus(1'b1, `SWL_IDX_WDOG_MODE, {4'h0, wd, 3'h0}, 32'h0);
    bus(1'b1, `SWL_IDX_PRIMARY, pri, 32'h0);
    bus(1'b1, `SWL_IDX_SECONDARY, sec, 32'h0);
    dir <= d;
    target <= idle;
    lag <= 4'($urandom() % 6);
    repeat (10) @(posedge ref_clk);
    stop_req <= 1'b1;
    @(posedge ref_clk);
    stop_req <= 1'b0;
    repeat (8) @(posedge ref_clk);
    `SWL_CHK(in_stop, 1'b1, "stop entry")
    `SWL_CHK(wdt_run, wd, "watchdog in stop")
    target <= act;
    for (int n = 0; n < 40 && in_stop !== 1'b0; n++) @(posedge ref_clk);
    `SWL_CHK(in_stop, 1'b0, "wake")
    bus(1'b0, `SWL_IDX_PRIMARY, 8'h00, 32'h80);
  endtask

  initial begin
    logic [23:0] m, low, idle, act;
    logic [2:0] c;
    logic lv, s;
    int n;
    masks = '{`SWL_MASK_1, `SWL_MASK_2, `SWL_MASK_3, `SWL_MASK_4, `SWL_MASK_5,
              `SWL_MASK_6, `SWL_MASK_7};
    void'($urandom(82356));
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    for (n = 0; n < 50 && global_reset !== 1'b0; n++) @(posedge ref_clk);
    `SWL_CHK(wdt_run, 1'b1, "watchdog after reset")
    bus(1'b0, `SWL_IDX_WDOG_MODE, 8'h00, 32'h08);
    bus(1'b1, `SWL_IDX_SECONDARY, 8'hff, 32'h0);
    bus(1'b0, `SWL_IDX_SECONDARY, 8'h00, 32'h0);
    bus(1'b1, `SWL_IDX_PRIMARY, 8'h7f, 32'h0);
    bus(1'b0, `SWL_IDX_PRIMARY, 8'h00, 32'h0);
    bus(1'b0, 6'h01, 8'h00, 32'h0);
    for (int i = 1; i < 15; i++) begin
      c = 3'((i + 1) / 2);
      lv = i[0];
      m = masks[c];
      low = m & (~m + 24'h1);
      idle = (m & {24{lv}}) | (~m & 24'($urandom()));
      act = ((idle & ~m) | (m & {24{~lv}})) ^ low;
      s = 1'($urandom());
      wake(s ? 8'h00 : {2'h0, lv, c, 2'h0}, s ? {1'h0, lv, 1'h0, c, 2'h0} : 8'h00,
           1'($urandom()), idle, act, (~m & 24'($urandom())) | low);
    end
    wake(8'h2c, 8'h04, 1'b1, 24'h0e0000, 24'h0e0f00, 24'h0);
    bus(1'b0, `SWL_IDX_STATUS, 8'h00, 32'h0a);
    bus(1'b1, `SWL_IDX_WDOG_MODE, 8'h00, 32'h0);
    vdd_low <= 1'b1;
    for (n = 0; n < 10 && global_reset !== 1'b1; n++) @(posedge ref_clk);
    repeat (20) @(posedge ref_clk);
    `SWL_CHK(global_reset, 1'b1, "held in brown-out")
    vdd_low <= 1'b0;
    for (n = 0; n < 100 && global_reset !== 1'b0; n++) @(posedge ref_clk);
    `SWL_CHK(n >= POR && n <= POR + 4, 1'b1, "power-on length")
    bus(1'b0, `SWL_IDX_WDOG_MODE, 8'h00, 32'h08);
    repeat (4) @(posedge ref_clk);
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    tally_and_finish();
  end
endmodule
